// file: logic/lcg_consts.svh
// Constants for the line clock generator configuration block
// Function
// - Data register accesses the element chosen by the held select control type.
// - Control type: 0 setup,1 terminal,2 numerator,3 ref divisor,4-7 factors.
// - Setup bit 6 picks synthesizers (1) or external port receive clocks (0).
// - Setup bit 5 swaps sysclk/24 for generator outputs when source is 0x20.
// - Setup bit 4 feeds generators from reference clock (1) or system clock.
// - Type 1 sets pre-scaler terminal count; denominator is value plus one.
// - Type 2 sets pre-scaler numerator, used with the programmed denominator.
// - Type 3 is low byte of 9-bit count; divide ratio is value plus 257.
// - Type 4 holds the eight low bandwidth factor bits, 8 kbit/s each.
// - Type 5 holds factor msb, worth 2048 kbit/s when set.
// - Types 4,5: select bit 4 picks transmit group, bits 3-0 the group.
`ifndef LCG_CONSTS_SVH
`define LCG_CONSTS_SVH
`define LCG_SEL_INDEX     16'h0416
`define LCG_DATA_INDEX    16'h0417
`define LCG_SEL_ADDR      16'h1058
`define LCG_DATA_ADDR     16'h105c
`define LCG_RESET_BYTE    8'h00
`define LCG_RESET_BIT     1'b0
`define LCG_CTYPE_HI      7
`define LCG_CTYPE_LO      5
`define LCG_SEL_DIR       4
`define LCG_SEL_NUM_HI    4
`define LCG_BIT_SYNTH     6
`define LCG_BIT_SUBST     5
`define LCG_BIT_CLKSEL    4
`define LCG_SETUP_MASK    8'h70
`define LCG_MSB_MASK      8'h01
`define LCG_TSRC_GEN      8'h20
`define LCG_REFDIV_BASE   9'h101
`define LCG_DEN_PLUS      9'h001
`define LCG_MEM_AW        7
`define LCG_MEM_DEPTH     128
`endif

// file: logic/lcg_pkg.sv
// Types for the line clock generator configuration block
package lcg_pkg;
	typedef enum logic [2:0] {
		LCG_CT_SETUP    = 3'h0,
		LCG_CT_PRE_TC   = 3'h1,
		LCG_CT_PRE_NUM  = 3'h2,
		LCG_CT_REF_DIV  = 3'h3,
		LCG_CT_GRP_LO   = 3'h4,
		LCG_CT_GRP_HI   = 3'h5,
		LCG_CT_SYN_LO   = 3'h6,
		LCG_CT_SYN_HI   = 3'h7
	} lcg_ctype_e;
	typedef logic [7:0] lcg_byte_t;
endpackage : lcg_pkg

// file: logic/lcg_mem_if.sv
// Port bundle between the configuration logic and its element memory
`timescale 1ns/10ps
`default_nettype none
interface lcg_mem_if;
	logic                we;
	logic [6:0]          addr;
	lcg_pkg::lcg_byte_t  wdata;
	lcg_pkg::lcg_byte_t  rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface : lcg_mem_if
`default_nettype wire

// file: logic/lcg_elem_mem.sv
// Per-group and per-port factor storage with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "lcg_consts.svh"
module lcg_elem_mem (
	input  wire logic  pclk,
	input  wire logic  presetn,
	lcg_mem_if.mem     mif
);
	lcg_pkg::lcg_byte_t  store_reg [`LCG_MEM_DEPTH];
	// Reset clears every entry so factors read zero before programming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `LCG_MEM_DEPTH; i++) begin
				store_reg[i] <= `LCG_RESET_BYTE;
			end
			mif.rdata <= `LCG_RESET_BYTE;
		end else begin
			if (mif.we) begin
				store_reg[mif.addr] <= mif.wdata;
			end
			mif.rdata <= store_reg[mif.addr];
		end
	end
endmodule : lcg_elem_mem
`default_nettype wire

// file: logic/lcg_top.sv
// Line clock generator configuration: APB select/data pair and dividers
`timescale 1ns/10ps
`default_nettype none
`include "lcg_consts.svh"
module lcg_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  group_timing_source,
	input  wire logic        gen_input_tick,
	output var  logic        rx_synth_enable,
	output var  logic        substitute_line_clock_gen,
	output var  logic        gen_input_clock_select,
	output logic             gen_outputs_in_use,
	output var  logic        prescale_tick,
	output var  logic        ref_div_tick
);
	lcg_mem_if mif ();

	logic [7:0]          sel_reg;
	logic                synth_reg;
	logic                subst_reg;
	logic                clksel_reg;
	lcg_pkg::lcg_byte_t  pre_tc_reg;
	lcg_pkg::lcg_byte_t  pre_num_reg;
	lcg_pkg::lcg_byte_t  ref_div_reg;
	logic                ack_reg;
	logic [31:0]         rdata_reg;
	logic                err_reg;
	logic [8:0]          acc_reg;
	logic [8:0]          acc_next;
	logic                pre_hit;
	logic [8:0]          ref_cnt_reg;
	logic [8:0]          ref_cnt_next;
	logic                ref_hit;

	// Fractional step: add numerator, wrap at denominator
	function automatic logic [9:0] frac_step(input logic [8:0] acc,
			input logic [7:0] num, input logic [8:0] den);
		logic [9:0] sum;
		sum = {1'b0, acc} + {2'b00, num};
		if (sum >= {1'b0, den}) begin
			frac_step = {1'b1, 9'(sum - {1'b0, den})};
		end else begin
			frac_step = {1'b0, sum[8:0]};
		end
	endfunction : frac_step

	lcg_elem_mem u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.mif     (mif)
	);

	lcg_pkg::lcg_ctype_e ctype;
	wire        hit_sel   = (paddr == `LCG_SEL_ADDR);
	wire        hit_data  = (paddr == `LCG_DATA_ADDR);
	wire        mapped    = hit_sel | hit_data;
	wire        access    = psel & penable;
	wire        wr_commit = access & ack_reg & pwrite & mapped;
	wire        wr_data   = wr_commit & hit_data;
	wire        is_mem    = ctype[2];
	wire [8:0]  pre_den   = {1'b0, pre_tc_reg} + `LCG_DEN_PLUS;
	wire [8:0]  ref_tc    = {1'b0, ref_div_reg} + `LCG_REFDIV_BASE;
	wire [7:0]  wbyte     = pwdata[7:0];
	wire [7:0]  setup_rd  = {1'b0, synth_reg, subst_reg, clksel_reg, 4'h0};
	wire [9:0]  step      = frac_step(acc_reg, pre_num_reg, pre_den);

	assign ctype = lcg_pkg::lcg_ctype_e'(sel_reg[`LCG_CTYPE_HI:`LCG_CTYPE_LO]);
	// Groups: select bit 4 = direction, 3-0 = group; ports use all five
	assign mif.addr  = {ctype[1:0], sel_reg[`LCG_SEL_NUM_HI:0]};
	assign mif.we    = wr_data & is_mem;
	// Only the defined msb survives for the group factor-high byte (type 5); type 7 keeps all eight bits
	assign mif.wdata = (ctype == lcg_pkg::LCG_CT_GRP_HI) ?
		(wbyte & `LCG_MSB_MASK) : wbyte;

	assign gen_outputs_in_use = subst_reg &
		(group_timing_source == `LCG_TSRC_GEN);

	assign pre_hit      = step[9];
	assign acc_next     = gen_input_tick ? step[8:0] : acc_reg;
	assign ref_hit      = gen_input_tick & (ref_cnt_reg == 9'(ref_tc - 9'h001));
	assign ref_cnt_next = ref_hit ? 9'h000 :
		(gen_input_tick ? 9'(ref_cnt_reg + 9'h001) : ref_cnt_reg);

	// Read data selected by the held control type
	logic [7:0] rd_byte;
	always_comb begin
		unique case (ctype)
			lcg_pkg::LCG_CT_SETUP:   rd_byte = setup_rd;
			lcg_pkg::LCG_CT_PRE_TC:  rd_byte = pre_tc_reg;
			lcg_pkg::LCG_CT_PRE_NUM: rd_byte = pre_num_reg;
			lcg_pkg::LCG_CT_REF_DIV: rd_byte = ref_div_reg;
			lcg_pkg::LCG_CT_GRP_LO,
			lcg_pkg::LCG_CT_GRP_HI,
			lcg_pkg::LCG_CT_SYN_LO,
			lcg_pkg::LCG_CT_SYN_HI:  rd_byte = mif.rdata;
		endcase
	end

	wire [31:0] rd_word = hit_sel ? {24'h000000, sel_reg} :
		(hit_data ? {24'h000000, rd_byte} : 32'h00000000);

	assign pready  = ack_reg;
	assign pslverr = err_reg;
	assign prdata  = rdata_reg;

	// One wait state: read byte is captured in the first access cycle, returned with pready in the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg   <= 1'b0;
			err_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= access & ~ack_reg;
			err_reg   <= access & ~ack_reg & ~mapped;
			rdata_reg <= (access & ~ack_reg & ~pwrite) ? rd_word : rdata_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= `LCG_RESET_BYTE;
		end else if (wr_commit & hit_sel) begin
			sel_reg <= wbyte;
		end
	end

	// Setup bits; reserved bits are not stored and read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			synth_reg  <= `LCG_RESET_BIT;
			subst_reg  <= `LCG_RESET_BIT;
			clksel_reg <= `LCG_RESET_BIT;
		end else if (wr_data & (ctype == lcg_pkg::LCG_CT_SETUP)) begin
			synth_reg  <= wbyte[`LCG_BIT_SYNTH];
			subst_reg  <= wbyte[`LCG_BIT_SUBST];
			clksel_reg <= wbyte[`LCG_BIT_CLKSEL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_tc_reg  <= `LCG_RESET_BYTE;
			pre_num_reg <= `LCG_RESET_BYTE;
			ref_div_reg <= `LCG_RESET_BYTE;
		end else begin
			if (wr_data & (ctype == lcg_pkg::LCG_CT_PRE_TC)) begin
				pre_tc_reg <= wbyte;
			end
			if (wr_data & (ctype == lcg_pkg::LCG_CT_PRE_NUM)) begin
				pre_num_reg <= wbyte;
			end
			if (wr_data & (ctype == lcg_pkg::LCG_CT_REF_DIV)) begin
				ref_div_reg <= wbyte;
			end
		end
	end

	assign rx_synth_enable           = synth_reg;
	assign substitute_line_clock_gen = subst_reg;
	assign gen_input_clock_select    = clksel_reg;

	// Dividers advance on the generator input tick from the clock mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg       <= 9'h000;
			prescale_tick <= 1'b0;
			ref_cnt_reg   <= 9'h000;
			ref_div_tick  <= 1'b0;
		end else begin
			acc_reg       <= acc_next;
			prescale_tick <= gen_input_tick & pre_hit;
			ref_cnt_reg   <= ref_cnt_next;
			ref_div_tick  <= ref_hit;
		end
	end
endmodule : lcg_top
`default_nettype wire

// file: verif/lcg_checker_sva.sv
// Port-level assertions for the line clock generator configuration block
`timescale 1ns/10ps
`default_nettype none
module lcg_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  group_timing_source,
	input wire logic        gen_input_tick,
	input wire logic        rx_synth_enable,
	input wire logic        substitute_line_clock_gen,
	input wire logic        gen_input_clock_select,
	input wire logic        gen_outputs_in_use,
	input wire logic        prescale_tick,
	input wire logic        ref_div_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] sel_q;
	wire        done = psel && penable && pready;
	wire        wset = done && pwrite && paddr == 16'h105c && sel_q[7:5] == 0;
	// Shadow of the select byte so setup writes can be told apart
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sel_q <= 8'h00;
		else if (done && pwrite && paddr == 16'h1058)
			sel_q <= pwdata[7:0];
	AST_ACK_SECOND: assert property (
		psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ack not in second access cycle");
	AST_ACK_ONE: assert property (pready |=> !pready)
		else $error("ack longer than one cycle");
	AST_ERR_MAP: assert property (done |->
		pslverr == !(paddr == 16'h1058 || paddr == 16'h105c))
		else $error("error response wrong");
	AST_SYN_BIT: assert property (
		wset |=> rx_synth_enable == $past(pwdata[6]))
		else $error("synth enable not from bit 6");
	AST_SUB_BIT: assert property (
		wset |=> substitute_line_clock_gen == $past(pwdata[5]))
		else $error("substitute not from bit 5");
	AST_CLK_BIT: assert property (
		wset |=> gen_input_clock_select == $past(pwdata[4]))
		else $error("clock select not from bit 4");
	AST_GEN_USE: assert property (gen_outputs_in_use ==
		(substitute_line_clock_gen && group_timing_source == 8'h20))
		else $error("generator use wrong");
	AST_SET_KEEP: assert property (done && pwrite && !wset |=>
		$stable({rx_synth_enable, substitute_line_clock_gen,
		gen_input_clock_select}))
		else $error("setup changed by other write");
	AST_PRE_TICK: assert property (
		prescale_tick |-> $past(gen_input_tick))
		else $error("prescale pulse without tick");
	AST_REF_TICK: assert property (
		ref_div_tick |-> $past(gen_input_tick))
		else $error("ref pulse without tick");
	cover property (wset);
	cover property (done && pslverr);
	cover property (ref_div_tick);
endmodule : lcg_checker
bind lcg_top lcg_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .group_timing_source,
	.gen_input_tick, .rx_synth_enable, .substitute_line_clock_gen,
	.gen_input_clock_select, .gen_outputs_in_use, .prescale_tick,
	.ref_div_tick);
`default_nettype wire

// file: verif/line_clock_gen_config_test.sv
// Self-checking bench for the line clock generator configuration block
`timescale 1ns/10ps
`default_nettype none
`include "lcg_consts.svh"
module line_clock_gen_config_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, gen_input_tick = 1'b0, pready, pslverr;
	logic        rx_synth_enable, substitute_line_clock_gen;
	logic        gen_input_clock_select, gen_outputs_in_use;
	logic        prescale_tick, ref_div_tick;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0]  group_timing_source = 8'h00, d;
	logic [7:0]  v [1:7];
	logic [32:0] exp_q [$];
	int          bad_count = 0, compares = 0, pc = 0, rc = 0;
	lcg_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .group_timing_source, .gen_input_tick,
		.rx_synth_enable, .substitute_line_clock_gen,
		.gen_input_clock_select, .gen_outputs_in_use, .prescale_tick,
		.ref_div_tick);
	always #5 pclk = ~pclk;
	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [32:0] e, input logic [32:0] g,
		input string nm);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Reads complete here; expectations were queued by the driver
	always @(posedge pclk) begin
		pc += prescale_tick;
		rc += ref_div_tick;
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(exp_q.pop_front(), {pslverr, prdata}, "read");
	end
	task automatic apb(input logic [15:0] a, input logic w,
		input logic [7:0] b);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, b};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			final_report();
		end
	endtask : apb
	task automatic sd(input logic [7:0] s, input logic [7:0] b);
		apb(`LCG_SEL_ADDR, 1'b1, s);
		apb(`LCG_DATA_ADDR, 1'b1, b);
	endtask : sd
	task automatic rsd(input logic [7:0] s, input logic [7:0] e);
		apb(`LCG_SEL_ADDR, 1'b1, s);
		exp_q.push_back({1'b0, 24'h0, e});
		apb(`LCG_DATA_ADDR, 1'b0, 8'h00);
	endtask : rsd
	initial begin
		void'($urandom(32'h7a77));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int t = 0; t < 8; t++)
			rsd({3'(t), 5'h00}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			d = {1'b0, 3'(i), 4'h0};
			group_timing_source <= i[0] ? 8'h20 : 8'($urandom) & 8'h1f;
			sd(8'h00, d);
			@(negedge pclk);
			chk(d[6], rx_synth_enable, "synth");
			chk(d[5], substitute_line_clock_gen, "subst");
			chk(d[4], gen_input_clock_select, "clksel");
			chk(i[0] & i[1], gen_outputs_in_use, "genuse");
			rsd(8'h00, d);
		end
		for (int t = 1; t < 8; t++) begin
			v[t] = t == 5 ? 8'($urandom) & 8'h01 : 8'($urandom);
			sd({3'(t), t > 3 ? 5'h13 : 5'h00}, v[t]);
		end
		sd(8'h83, ~v[4]);
		for (int t = 1; t < 8; t++)
			rsd({3'(t), t > 3 ? 5'h13 : 5'h00}, v[t]);
		rsd(8'h83, ~v[4]);
		// Unmapped write must leave the select byte untouched
		apb(16'h1060, 1'b1, 8'hff);
		exp_q.push_back({1'b0, 24'h0, 8'h83});
		apb(`LCG_SEL_ADDR, 1'b0, 8'h00);
		exp_q.push_back({1'b1, 32'h0});
		apb(16'h1060, 1'b0, 8'h00);
		sd(8'h20, 8'h03);
		sd(8'h40, 8'h01);
		sd(8'h60, 8'h03);
		gen_input_tick <= 1'b1;
		repeat (520) @(posedge pclk);
		gen_input_tick <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(33'd130, 33'(pc), "prescale");
		chk(33'd2, 33'(rc), "refdiv");
		final_report();
	end
endmodule : line_clock_gen_config_test
`default_nettype wire
